// [ipc_core_model.sv]
// Core model: acknowledges a take after a set wait, owns the disable flag.
// Assumes take stays high until the ack edge.
`timescale 1ns/10ps
module ipc_core_model (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_irq_take,
  input wire logic i_set_disable_flag,
  input wire logic i_clear_flag,
  input wire logic [3:0] i_wait,
  output logic o_accept_ack,
  output logic o_disable_flag
);
  logic [3:0] cnt_q;
  // Stack push and vector fetch run together; ack marks both done
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 4'h0;
      o_accept_ack <= 1'b0;
    end else if (o_accept_ack || !i_irq_take) begin
      cnt_q <= 4'h0;
      o_accept_ack <= 1'b0;
    end else if (cnt_q == i_wait) begin
      o_accept_ack <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_disable_flag <= 1'b0;
    end else if (i_set_disable_flag) begin
      o_disable_flag <= 1'b1;
    end else if (i_clear_flag) begin
      o_disable_flag <= 1'b0;
    end
  end
endmodule

// [ipc_edge.sv]
// Edge detector for one synchronous pin with selectable polarity.
// Assumes the pin is already synchronous to i_clock.
`timescale 1ns/10ps
module ipc_edge (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_pin,
  input wire logic i_rising,
  output logic o_hit
);
  logic pin_q;
  logic sel_q;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pin_q <= 1'b0;
      sel_q <= 1'b0;
    end else begin
      pin_q <= i_pin;
      sel_q <= i_rising;
    end
  end
  // Changing the polarity looks at the pin through the new selection, so it may
  // report an edge the pin never made; software is expected to tolerate that.
  always_comb begin
    o_hit = sel_q ? (i_pin & ~pin_q) : (~i_pin & pin_q);
    if (sel_q != i_rising) begin
      o_hit = o_hit | (i_rising ? i_pin : ~i_pin);
    end
  end
endmodule

// [ipc_pkg.sv]
// Package for the interrupt priority controller: register map, bit layout, vectors.
// Assumes a 32-bit APB slave with each register on one aligned word.
package ipc_pkg;
  localparam int unsigned IPC_NSRC = 12;
  localparam logic [7:0] IPC_OFS_REQ = 8'h00;
  localparam logic [7:0] IPC_OFS_EN = 8'h04;
  localparam logic [7:0] IPC_OFS_EDGE = 8'h08;
  localparam logic [7:0] IPC_OFS_STAT = 8'h0c;
  localparam logic [7:0] IPC_OFS_KEYDIR = 8'h10;
  localparam logic [11:0] IPC_EN_RST = 12'h000;
  localparam logic [3:0] IPC_EDGE_RST = 4'h0;
  localparam logic [7:0] IPC_KEYDIR_RST = 8'hff;
  // Request bit positions, highest priority first
  localparam int unsigned SRC_RX = 0;
  localparam int unsigned SRC_TX = 1;
  localparam int unsigned SRC_EXT0 = 2;
  localparam int unsigned SRC_EXT1 = 3;
  localparam int unsigned SRC_KEY = 4;
  localparam int unsigned SRC_CNT0 = 5;
  localparam int unsigned SRC_CNT1 = 6;
  localparam int unsigned SRC_TMRX = 7;
  localparam int unsigned SRC_TMRA = 8;
  localparam int unsigned SRC_AD = 9;
  localparam int unsigned SRC_TMR1 = 10;
  localparam int unsigned SRC_BRK = 11;
  // Edge select bits: 1 selects rising
  localparam int unsigned EDG_EXT0 = 0;
  localparam int unsigned EDG_EXT1 = 1;
  localparam int unsigned EDG_CNT0 = 2;
  localparam int unsigned EDG_CNT1 = 3;
  localparam logic [15:0] IPC_VEC_RESET = 16'hfffc;
  localparam logic [15:0] IPC_VEC_BRK = 16'hffdc;
  localparam logic [15:0] IPC_VEC_TABLE [IPC_NSRC] = '{
    16'hfffa, 16'hfff8, 16'hfff6, 16'hfff4, 16'hfff2, 16'hfff0,
    16'hffee, 16'hffec, 16'hffe6, 16'hffe2, 16'hffe0, 16'hffdc};
  typedef struct packed {
    logic valid;
    logic [3:0] src;
    logic [15:0] vec;
  } ipc_take_t;
  typedef enum logic [1:0] {
    IPC_ST_RESET = 2'b00,
    IPC_ST_IDLE = 2'b01,
    IPC_ST_TAKE = 2'b10,
    IPC_ST_WAIT = 2'b11
  } ipc_state_t;
endpackage

// [ipc_top.sv]
// Interrupt priority controller: request latches, enables, priority, accept handshake.
// Assumes the core raises i_accept_ack after stacking PC and status, and that
// peripheral event inputs are one-cycle pulses synchronous to i_clock.
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
module ipc_top
  import ipc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_ext_irq_pin0,
  input wire logic i_ext_irq_pin1,
  input wire logic i_counter_pin0,
  input wire logic i_counter_pin1,
  input wire logic [7:0] i_key_input_port,
  input wire logic i_serial_rx_done,
  input wire logic i_serial_tx_shift_done,
  input wire logic i_serial_tx_buf_empty,
  input wire logic i_timer1_underflow,
  input wire logic i_timera_underflow,
  input wire logic i_timerx_underflow,
  input wire logic i_ad_done,
  input wire logic i_break_instruction,
  input wire logic i_disable_flag,
  input wire logic i_accept_ack,
  output logic o_irq_take,
  output logic [3:0] o_irq_src,
  output logic [15:0] o_irq_vector,
  output logic o_irq_is_reset,
  output logic o_set_disable_flag
);
  logic [11:0] req_q;
  logic [11:0] en_q;
  logic [3:0] edge_q;
  logic [7:0] keydir_q;
  logic key_and_q;
  logic [11:0] hw_set;
  logic [11:0] sw_clr;
  logic [11:0] acc_clr;
  logic [11:0] ready;
  logic hit_ext0;
  logic hit_ext1;
  logic hit_cnt0;
  logic hit_cnt1;
  logic key_and;
  logic wr_en;
  logic rd_en;
  ipc_state_t state_q;
  ipc_take_t take_q;
  ipc_take_t pick;

  // Lowest index wins, which gives the documented order
  function automatic logic [3:0] ipc_first(input logic [11:0] vec);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = IPC_NSRC - 1; i >= 0; i--) begin
      if (vec[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  ipc_edge u_edge_ext0 (.i_clock(i_clock), .i_rst(i_rst), .i_pin(i_ext_irq_pin0),
    .i_rising(edge_q[EDG_EXT0]), .o_hit(hit_ext0));
  ipc_edge u_edge_ext1 (.i_clock(i_clock), .i_rst(i_rst), .i_pin(i_ext_irq_pin1),
    .i_rising(edge_q[EDG_EXT1]), .o_hit(hit_ext1));
  ipc_edge u_edge_cnt0 (.i_clock(i_clock), .i_rst(i_rst), .i_pin(i_counter_pin0),
    .i_rising(edge_q[EDG_CNT0]), .o_hit(hit_cnt0));
  ipc_edge u_edge_cnt1 (.i_clock(i_clock), .i_rst(i_rst), .i_pin(i_counter_pin1),
    .i_rising(edge_q[EDG_CNT1]), .o_hit(hit_cnt1));

  // Output pins (direction bit 1) are left out of the AND
  assign key_and = &(i_key_input_port | keydir_q);

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      key_and_q <= 1'b1;
    end else begin
      key_and_q <= key_and;
    end
  end

  always_comb begin
    hw_set = '0;
    hw_set[SRC_RX] = i_serial_rx_done;
    hw_set[SRC_TX] = i_serial_tx_shift_done | i_serial_tx_buf_empty;
    hw_set[SRC_EXT0] = hit_ext0;
    hw_set[SRC_EXT1] = hit_ext1;
    hw_set[SRC_KEY] = key_and_q & ~key_and;
    hw_set[SRC_CNT0] = hit_cnt0;
    hw_set[SRC_CNT1] = hit_cnt1;
    hw_set[SRC_TMRX] = i_timerx_underflow;
    hw_set[SRC_TMRA] = i_timera_underflow;
    hw_set[SRC_AD] = i_ad_done;
    hw_set[SRC_TMR1] = i_timer1_underflow;
    hw_set[SRC_BRK] = i_break_instruction;
  end

  assign wr_en = i_psel & i_penable & i_pwrite;
  assign rd_en = i_psel & ~i_penable & ~i_pwrite;

  // Writing 0 clears a request; writing 1 leaves it alone
  always_comb begin
    sw_clr = '0;
    if (wr_en && i_paddr == IPC_OFS_REQ) begin
      sw_clr = ~i_pwdata[11:0];
    end
  end

  always_comb begin
    acc_clr = '0;
    if (state_q == IPC_ST_TAKE && take_q.valid && i_accept_ack) begin
      acc_clr[take_q.src] = 1'b1;
    end
  end

  // A new event in the clearing cycle survives
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      req_q <= '0;
    end else begin
      req_q <= (req_q & ~sw_clr & ~acc_clr) | hw_set;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      en_q <= IPC_EN_RST;
      edge_q <= IPC_EDGE_RST;
      keydir_q <= IPC_KEYDIR_RST;
    end else if (wr_en) begin
      case (i_paddr)
        IPC_OFS_EN: en_q <= i_pwdata[11:0];
        IPC_OFS_EDGE: edge_q <= i_pwdata[3:0];
        IPC_OFS_KEYDIR: keydir_q <= i_pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Break has no enable and no mask
  always_comb begin
    ready = req_q & en_q & {12{~i_disable_flag}};
    ready[SRC_BRK] = req_q[SRC_BRK];
  end

  always_comb begin
    pick.valid = |ready;
    pick.src = ipc_first(ready);
    pick.vec = IPC_VEC_TABLE[pick.src];
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_q <= IPC_ST_RESET;
      take_q <= '0;
      o_irq_take <= 1'b0;
      o_irq_src <= 4'h0;
      o_irq_vector <= 16'h0000;
      o_irq_is_reset <= 1'b0;
      o_set_disable_flag <= 1'b0;
    end else begin
      o_set_disable_flag <= 1'b0;
      case (state_q)
        IPC_ST_RESET: begin
          // Reset is served like the top interrupt, through the same handshake
          o_irq_take <= 1'b1;
          o_irq_is_reset <= 1'b1;
          o_irq_vector <= IPC_VEC_RESET;
          o_irq_src <= 4'h0;
          take_q <= '0;
          state_q <= IPC_ST_TAKE;
        end
        IPC_ST_IDLE: begin
          if (pick.valid) begin
            take_q <= pick;
            o_irq_take <= 1'b1;
            o_irq_is_reset <= 1'b0;
            o_irq_src <= pick.src;
            o_irq_vector <= pick.vec;
            state_q <= IPC_ST_TAKE;
          end
        end
        IPC_ST_TAKE: begin
          if (i_accept_ack) begin
            o_irq_take <= 1'b0;
            o_set_disable_flag <= 1'b1;
            state_q <= IPC_ST_WAIT;
          end
        end
        IPC_ST_WAIT: begin
          // One cycle for the core's flag and the cleared bit to settle
          state_q <= IPC_ST_IDLE;
        end
        default: state_q <= IPC_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= rd_en | (i_psel & ~i_penable & i_pwrite);
      o_pslverr <= 1'b0;
      if (i_psel & ~i_penable) begin
        if (!(i_paddr inside {IPC_OFS_REQ, IPC_OFS_EN, IPC_OFS_EDGE, IPC_OFS_STAT,
            IPC_OFS_KEYDIR})) begin
          o_pslverr <= 1'b1;
        end
      end
      if (rd_en) begin
        case (i_paddr)
          IPC_OFS_REQ: o_prdata <= {20'h0, req_q};
          IPC_OFS_EN: o_prdata <= {20'h0, en_q};
          IPC_OFS_EDGE: o_prdata <= {28'h0, edge_q};
          IPC_OFS_STAT: o_prdata <= {24'h0, state_q, take_q.valid, take_q.src,
            key_and_q};
          IPC_OFS_KEYDIR: o_prdata <= {24'h0, keydir_q};
          default: o_prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// [ipc_top_chk.sv]
// Checker for the interrupt controller: accept handshake, vectors, APB timing.
// Sees only the ports of ipc_top; bound from the testbench top file.
`timescale 1ns/10ps
module ipc_top_chk
  import ipc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_disable_flag,
  input wire logic i_accept_ack,
  input wire logic o_irq_take,
  input wire logic [3:0] o_irq_src,
  input wire logic [15:0] o_irq_vector,
  input wire logic o_irq_is_reset,
  input wire logic o_set_disable_flag
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  sequence wait_s; o_irq_take && !i_accept_ack; endsequence
  sequence acc_s; o_irq_take && i_accept_ack; endsequence
  take_hold_a:
    assert property (wait_s |=> o_irq_take) else $error("take dropped before ack");
  accept_end_a:
    assert property (acc_s |=> !o_irq_take && o_set_disable_flag ##1 !o_irq_take
      && !o_set_disable_flag) else $error("accept sequence wrong");
  set_cause_a:
    assert property ($rose(o_set_disable_flag) |-> $past(o_irq_take && i_accept_ack))
      else $error("disable pulse without accept");
  vec_map_a:
    assert property (o_irq_take && !o_irq_is_reset |-> o_irq_vector
      == IPC_VEC_TABLE[o_irq_src]) else $error("vector does not match source");
  reset_vec_a:
    assert property (o_irq_take && o_irq_is_reset |-> o_irq_vector == IPC_VEC_RESET)
      else $error("reset vector wrong");
  mask_flag_a:
    assert property ($rose(o_irq_take) && !o_irq_is_reset && o_irq_src != 4'd11
      |-> !$past(i_disable_flag)) else $error("masked source taken");
  apb_answer_a:
    assert property (i_psel && !i_penable |=> o_pready) else $error("no pready");
  apb_single_a:
    assert property (o_pready |=> !o_pready) else $error("pready too long");
  apb_err_a:
    assert property (o_pslverr |-> o_pready) else $error("pslverr without pready");
endmodule

// [test_interrupt_priority_controller.sv]
// Self-checking bench for ipc_top with a core model on the accept side.
// Assumes ipc_pkg, ipc_edge, ipc_top and the checker are compiled first.
`timescale 1ns/10ps
module test_interrupt_priority_controller;
  import ipc_pkg::*;
  logic clk, rst, psel, penable, pwrite, p0, p1, c0, c1, ack, dis, clr, take, is_rst, setd;
  logic rdy, err;
  logic [7:0] paddr, key, ev;
  logic [31:0] pwdata, prdata;
  logic [32:0] rd;
  logic [3:0] src, wt_n;
  logic [15:0] vec;
  int miscompares, compares;
  ipc_top i_ipc_top(.i_clock(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(rdy), .o_pslverr(err), .i_ext_irq_pin0(p0), .i_ext_irq_pin1(p1),
    .i_counter_pin0(c0), .i_counter_pin1(c1), .i_key_input_port(key),
    .i_serial_rx_done(ev[0]), .i_serial_tx_shift_done(ev[1]), .i_serial_tx_buf_empty(ev[2]),
    .i_timer1_underflow(ev[3]), .i_timera_underflow(ev[4]), .i_timerx_underflow(ev[5]),
    .i_ad_done(ev[6]), .i_break_instruction(ev[7]), .i_disable_flag(dis),
    .i_accept_ack(ack), .o_irq_take(take), .o_irq_src(src), .o_irq_vector(vec),
    .o_irq_is_reset(is_rst), .o_set_disable_flag(setd));
  ipc_core_model i_ipc_core_model(.i_clock(clk), .i_rst(rst), .i_irq_take(take),
    .i_set_disable_flag(setd), .i_clear_flag(clr), .i_wait(wt_n), .o_accept_ack(ack),
    .o_disable_flag(dis));
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    if (rdy !== 1'b1) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, rdy, 1'b1);
    end
    rd = {err, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge between transfers, so psel is never driven twice in one step
    @(posedge clk);
  endtask
  task automatic pulse(input logic [7:0] m);
    ev <= m;
    @(posedge clk);
    ev <= 8'h00;
  endtask
  task automatic unmask;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask
  task automatic wt(input logic [15:0] v, input logic [3:0] s, input logic r);
    int n;
    n = 0;
    while (take !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk({take, is_rst, src, vec}, {1'b1, r, s, v});
    while (take === 1'b1 && n < 80) begin
      @(posedge clk);
      n++;
    end
    if (take === 1'b1) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, take, 1'b0);
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic t_regs;
    apb(1'b0, IPC_OFS_EN, 32'h0);
    chk(rd, {21'h0, IPC_EN_RST});
    apb(1'b0, IPC_OFS_KEYDIR, 32'h0);
    chk(rd, {25'h0, IPC_KEYDIR_RST});
    apb(1'b0, 8'h20, 32'h0);
    chk(rd, 33'h1_0000_0000);
    apb(1'b1, IPC_OFS_EN, 32'h0000_0fff);
    apb(1'b0, IPC_OFS_EN, 32'h0);
    chk(rd, 33'h0_0000_0fff);
  endtask
  task automatic t_mask;
    pulse(8'h40);
    repeat (10) @(posedge clk);
    chk(take, 1'b0);
    wt_n <= 4'h6;
    pulse(8'h80);
    wt(16'hffdc, 4'(SRC_BRK), 1'b0);
    wt_n <= 4'h0;
    unmask();
    wt(16'hffe2, 4'(SRC_AD), 1'b0);
  endtask
  task automatic t_prio;
    pulse(8'h09);
    unmask();
    wt(16'hfffa, 4'(SRC_RX), 1'b0);
    unmask();
    wt(16'hffe0, 4'(SRC_TMR1), 1'b0);
  endtask
  task automatic t_swclr;
    pulse(8'h36);
    apb(1'b0, IPC_OFS_REQ, 32'h0);
    chk(rd, 33'h182);
    apb(1'b1, IPC_OFS_REQ, 32'hffff_fe7d);
    apb(1'b0, IPC_OFS_REQ, 32'h0);
    chk(rd, 33'h0);
  endtask
  task automatic t_edges;
    apb(1'b1, IPC_OFS_KEYDIR, 32'h0000_00fe);
    p0 <= 1'b0;
    c1 <= 1'b0;
    key <= 8'hfe;
    repeat (4) @(posedge clk);
    apb(1'b0, IPC_OFS_REQ, 32'h0);
    chk(rd, 33'h54);
  endtask
  task automatic t_edgesel;
    apb(1'b1, IPC_OFS_EN, 32'h0000_0ff7);
    apb(1'b1, IPC_OFS_EDGE, 32'h0000_0002);
    apb(1'b0, IPC_OFS_REQ, 32'h0);
    chk(rd, 33'h5c);
    apb(1'b1, IPC_OFS_REQ, 32'hffff_fff7);
    apb(1'b0, IPC_OFS_REQ, 32'h0);
    chk(rd, 33'h54);
    apb(1'b1, IPC_OFS_EN, 32'h0000_0fff);
    p1 <= 1'b0;
    c0 <= 1'b0;
    repeat (2) @(posedge clk);
    apb(1'b0, IPC_OFS_REQ, 32'h0);
    chk(rd, 33'h74);
    p1 <= 1'b1;
    repeat (2) @(posedge clk);
    apb(1'b0, IPC_OFS_REQ, 32'h0);
    chk(rd, 33'h7c);
    unmask();
    wt(16'hfff6, 4'(SRC_EXT0), 1'b0);
    unmask();
    wt(16'hfff4, 4'(SRC_EXT1), 1'b0);
  endtask
  task automatic print_verdict;
    if (miscompares == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    miscompares++;
    print_verdict();
  end
  initial begin
    {rst, psel, penable, pwrite, clr} = 5'b10000;
    {p0, p1, c0, c1} = 4'hf;
    {paddr, key, ev, pwdata, wt_n} = {8'h00, 8'hff, 8'h00, 32'h0, 4'h2};
    miscompares = 0;
    compares = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wt(IPC_VEC_RESET, 4'h0, 1'b1);
    t_regs();
    t_mask();
    t_prio();
    t_swclr();
    t_edges();
    t_edgesel();
    print_verdict();
  end
endmodule
bind ipc_top ipc_top_chk i_ipc_top_chk(.i_clock(i_clock), .i_rst(i_rst), .i_psel(i_psel),
  .i_penable(i_penable), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_disable_flag(i_disable_flag), .i_accept_ack(i_accept_ack), .o_irq_take(o_irq_take),
  .o_irq_src(o_irq_src), .o_irq_vector(o_irq_vector), .o_irq_is_reset(o_irq_is_reset),
  .o_set_disable_flag(o_set_disable_flag));
